/* File: design/nisr_regs.svh */
// header: register offsets, command codes and timing counts for the NAND
// id/status/reset host controller. assumes a 125 MHz system clock.
`ifndef NISR_REGS_SVH
`define NISR_REGS_SVH

// =======================================
// apb register offsets
`define NISR_CTRL_OFS      12'h000
`define NISR_STAT_OFS      12'h004
`define NISR_ID0_OFS       12'h008
`define NISR_ID1_OFS       12'h00c
`define NISR_SREG_OFS      12'h010

// =======================================
// control fields
`define NISR_CTRL_GO_BIT   0
`define NISR_CTRL_OP_LSB   1
`define NISR_CTRL_OP_MSB   2
`define NISR_CTRL_WP_BIT   3

// =======================================
// nand command codes
`define NISR_CMD_ID        8'h90
`define NISR_CMD_STATUS    8'h70
`define NISR_CMD_READ      8'h00
`define NISR_CMD_RESET     8'hff
`define NISR_ID_ADDR       8'h00
`define NISR_ID_BYTES      3'h5

// =======================================
// timing: each bus phase lasts this many ns, rounded up to cycles
`define NISR_CLK_NS        8
`define NISR_PHASE_NS      40
`define NISR_PHASE_CYC     ((`NISR_PHASE_NS + `NISR_CLK_NS - 1) / `NISR_CLK_NS)

`endif

/* File: design/nisr_pkg.sv */
// package: types of the NAND id/status/reset host controller.
// assumes nisr_regs.svh supplies the numeric constants.
package nisr_pkg;

    typedef enum logic [1:0] {
        NISR_OP_ID     = 2'b00,
        NISR_OP_STATUS = 2'b01,
        NISR_OP_RESET  = 2'b10,
        NISR_OP_RESUME = 2'b11
    } nisr_op_t;

    typedef enum logic [3:0] {
        NISR_IDLE   = 4'b0000,
        NISR_CMD    = 4'b0001,
        NISR_ADDR   = 4'b0010,
        NISR_GAP    = 4'b0011,
        NISR_RDLO   = 4'b0100,
        NISR_RDHI   = 4'b0101,
        NISR_WAITRB = 4'b0110,
        NISR_DONE   = 4'b0111
    } nisr_state_t;

    // pins toward the flash; enables active low
    typedef struct packed {
        logic       chipEnableN;
        logic       cmdLatch;
        logic       addrLatch;
        logic       writeStrobeN;
        logic       read_strobe_n;
        logic       writeProtectN;
        logic [7:0] ioOut;
        logic       ioOeN;
    } nisr_pins_t;

endpackage : nisr_pkg

/* File: design/nisr_host.sv */
// host controller issuing id read, status read, reset and read-resume
// commands to a parallel NAND flash. software drives it over APB.
// assumes a pull-up on the board for ready_busy_n and an 8-bit flash.
//
// How it works
// [R01] device returns five id bytes in fixed order; all five are captured
// [R02] id command, one address cycle, then one read strobe per byte
// [R03] third id byte holds chip count, cell levels, upper nibble 1000
// [R04] fourth id byte holds page, block size, bus width, fixed bits
// [R05] fifth id byte holds district count and fixed bits
// [R06] each read strobe after status command yields the status byte
// [R07] status bit 1 is current result, validity depends on operation
// [R08] status bit 2 is previous cache page result while cache ready
// [R09] bit 6 page buffer ready, bit 7 cache ready, bits 3-5 zero
// [R10] bit 6 equals bit 7 unless prior command was cache program/read
// [R11] status bit 8 is one when not write protected
// [R12] pass/fail meaningful only for program/erase once ready
// [R13] status read accepted in mid read for readiness polling
// [R14] after status in read mode, read command resumes at old column
// [R15] reset command aborts operation and enters wait state
// [R16] reset during cache program may abort previous page too
// [R17] device stays busy a finite time after reset, then ready
// [R18] during power-on busy host sends only reset or status read
// [R19] host never sends command codes outside the defined set
// [R20] while busy host sends only status read or reset
// [R21] with shared ready/busy line use per-device status reads
// [R22] ready/busy line needs a pull-up since device only pulls low
`timescale 1ns/1ps
`include "nisr_regs.svh"

module nisr_host
    import nisr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output nisr_pins_t       pins,
    input  wire logic [7:0]  ioIn,
    input  wire logic        ready_busy_n
);

    // =======================================
    // pin synchronisers
    logic [7:0] ioMeta_reg;
    logic [7:0] ioSync_reg;
    logic       rbMeta_reg;
    logic       rbSync_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ioMeta_reg <= 8'h00;
            ioSync_reg <= 8'h00;
            rbMeta_reg <= 1'b0;
            rbSync_reg <= 1'b0;
        end else begin
            ioMeta_reg <= ioIn;
            ioSync_reg <= ioMeta_reg;
            rbMeta_reg <= ready_busy_n;   // [R22]
            rbSync_reg <= rbMeta_reg;
        end
    end

    // =======================================
    // registers and state
    nisr_state_t state_reg;
    nisr_op_t    op_reg;
    logic        busy;
    logic        wpN_reg;
    logic        done_reg;
    logic        refused_reg;
    logic [7:0]  idByte_reg [0:4];
    logic [7:0]  status_reg;
    logic [2:0]  byteCnt_reg;
    logic [3:0]  phaseCnt_reg;
    logic        phaseEnd;
    logic        apbWr;
    logic        goReq;
    nisr_op_t    goOp;
    logic        goLegal;

    assign busy     = (state_reg != NISR_IDLE);
    assign apbWr    = psel && penable && pwrite;
    assign goReq    = apbWr && (paddr == `NISR_CTRL_OFS) && pwdata[`NISR_CTRL_GO_BIT];
    assign goOp     = nisr_op_t'(pwdata[`NISR_CTRL_OP_MSB:`NISR_CTRL_OP_LSB]);
    // only status and reset while the flash is busy; read-resume needs ready
    assign goLegal  = rbSync_reg || (goOp == NISR_OP_STATUS) || (goOp == NISR_OP_RESET); // [R18] [R20]
    assign phaseEnd = (phaseCnt_reg == 4'(`NISR_PHASE_CYC - 1));
    assign pready   = 1'b1;
    assign pslverr  = 1'b0;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wpN_reg <= 1'b0;
        end else if (apbWr && paddr == `NISR_CTRL_OFS) begin
            wpN_reg <= pwdata[`NISR_CTRL_WP_BIT];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phaseCnt_reg <= 4'h0;
        end else if (!busy || phaseEnd) begin
            phaseCnt_reg <= 4'h0;
        end else begin
            phaseCnt_reg <= phaseCnt_reg + 4'h1;
        end
    end

    // =======================================
    // sequencer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg   <= NISR_IDLE;
            op_reg      <= NISR_OP_ID;
            byteCnt_reg <= 3'h0;
            done_reg    <= 1'b0;
            refused_reg <= 1'b0;
        end else begin
            case (state_reg)
                NISR_IDLE: begin
                    if (goReq && goLegal) begin
                        op_reg      <= goOp;
                        byteCnt_reg <= 3'h0;
                        done_reg    <= 1'b0;
                        refused_reg <= 1'b0;
                        state_reg   <= NISR_CMD;
                    end else if (goReq) begin
                        refused_reg <= 1'b1;
                    end
                end
                NISR_CMD: begin
                    if (phaseEnd) begin
                        case (op_reg)
                            NISR_OP_ID:     state_reg <= NISR_ADDR;   // [R02]
                            NISR_OP_STATUS: state_reg <= NISR_GAP;    // [R06] [R13]
                            NISR_OP_RESET:  state_reg <= NISR_WAITRB; // [R15] [R16]
                            default:        state_reg <= NISR_DONE;   // [R14]
                        endcase
                    end
                end
                NISR_ADDR: begin
                    if (phaseEnd) begin
                        state_reg <= NISR_GAP;
                    end
                end
                NISR_GAP: begin
                    if (phaseEnd) begin
                        state_reg <= NISR_RDLO;
                    end
                end
                NISR_RDLO: begin
                    if (phaseEnd) begin
                        state_reg <= NISR_RDHI;
                    end
                end
                NISR_RDHI: begin
                    if (phaseEnd) begin
                        byteCnt_reg <= byteCnt_reg + 3'h1;
                        if (op_reg == NISR_OP_ID && byteCnt_reg != `NISR_ID_BYTES - 3'h1) begin
                            state_reg <= NISR_RDLO;   // [R01] [R02]
                        end else begin
                            state_reg <= NISR_DONE;
                        end
                    end
                end
                NISR_WAITRB: begin
                    // flash pulls busy a while after reset; wait past it
                    if (phaseEnd && rbSync_reg) begin
                        state_reg <= NISR_DONE;   // [R17]
                    end
                end
                NISR_DONE: begin
                    done_reg  <= 1'b1;
                    state_reg <= NISR_IDLE;
                end
                default: state_reg <= NISR_IDLE;
            endcase
        end
    end

    // =======================================
    // data capture at the end of each read-strobe low phase
    logic capture;
    assign capture = (state_reg == NISR_RDLO) && phaseEnd;

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : gIdByte
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    idByte_reg[gi] <= 8'h00;
                end else if (capture && op_reg == NISR_OP_ID && byteCnt_reg == 3'(gi)) begin
                    idByte_reg[gi] <= ioSync_reg;   // [R01] [R03] [R04] [R05]
                end
            end
        end
    endgenerate

    // raw status kept; bits 1/2 judged by software only once ready
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_reg <= 8'h00;
        end else if (capture && op_reg == NISR_OP_STATUS) begin
            status_reg <= ioSync_reg;   // [R07] [R08] [R09] [R10] [R11] [R12] [R21]
        end
    end

    // =======================================
    // pin drive; only fixed legal command codes are emitted
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pins <= '{chipEnableN: 1'b1, cmdLatch: 1'b0, addrLatch: 1'b0, writeStrobeN: 1'b1,
                      read_strobe_n: 1'b1, writeProtectN: 1'b0, ioOut: 8'h00, ioOeN: 1'b1};
        end else begin
            pins.chipEnableN   <= !busy;
            pins.cmdLatch      <= (state_reg == NISR_CMD);
            pins.addrLatch     <= (state_reg == NISR_ADDR);
            pins.writeStrobeN  <= !(((state_reg == NISR_CMD) || (state_reg == NISR_ADDR)) && !phaseEnd);
            pins.read_strobe_n <= (state_reg != NISR_RDLO);
            pins.writeProtectN <= wpN_reg;
            pins.ioOeN         <= !((state_reg == NISR_CMD) || (state_reg == NISR_ADDR));
            case (op_reg)   // [R19]
                NISR_OP_ID:     pins.ioOut <= (state_reg == NISR_ADDR) ? `NISR_ID_ADDR : `NISR_CMD_ID;
                NISR_OP_STATUS: pins.ioOut <= `NISR_CMD_STATUS;
                NISR_OP_RESET:  pins.ioOut <= `NISR_CMD_RESET;
                default:        pins.ioOut <= `NISR_CMD_READ;
            endcase
        end
    end

    // =======================================
    // apb read data, loaded in the setup cycle so it stands through the access
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable) begin
            case (paddr)
                `NISR_CTRL_OFS: prdata <= {28'h0, wpN_reg, op_reg, 1'b0};
                `NISR_STAT_OFS: prdata <= {28'h0, refused_reg, rbSync_reg, done_reg, busy};
                `NISR_ID0_OFS:  prdata <= {idByte_reg[3], idByte_reg[2], idByte_reg[1], idByte_reg[0]};
                `NISR_ID1_OFS:  prdata <= {24'h0, idByte_reg[4]};
                `NISR_SREG_OFS: prdata <= {24'h0, status_reg};
                default:        prdata <= 32'h0;
            endcase
        end
    end

endmodule : nisr_host

/* File: tb/nisr_flash_model.sv */
// partner: behavioural nand device answering id, status, reset and resume
// assumes host strobes arrive as nisr_pins_t; ready line is open drain
`timescale 1ns/1ps
module nisr_flash_model
    import nisr_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE  = 8'h5a, // arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'h3c, // arbitrary value
    parameter int         BUSY_NS     = 1000
)
(
    input  wire nisr_pins_t pins,
    output logic            pullLow,
    output logic [7:0]      ioData
);
    logic [7:0] modeReg;
    logic [7:0] colReg;
    int         idIdx;
    // =======================================
    // power-on initialisation
    initial begin
        modeReg = 8'h70;
        colReg  = 8'h00;
        idIdx   = 0;
        ioData  = 8'h00;
        pullLow = 1'b1;
        #(BUSY_NS) pullLow = 1'b0;
    end
    // =======================================
    // command latch; reset stalls further commands, as a busy part would
    always @(posedge pins.writeStrobeN) begin
        if (!pins.chipEnableN && pins.cmdLatch) begin
            modeReg = pins.ioOut;
            idIdx   = 0;
            if (pins.ioOut == 8'hff) begin
                pullLow = 1'b1;
                #(BUSY_NS) pullLow = 1'b0;
            end
        end
    end
    always @(negedge pins.read_strobe_n) begin
        if (!pins.chipEnableN) begin
            case (modeReg)
                8'h90: ioData = (idIdx == 0) ? MAKER_CODE : (idIdx == 1) ? DEVICE_CODE :
                                (idIdx == 2) ? 8'h80 : (idIdx == 3) ? 8'h15 : 8'h72;
                8'h70: ioData = {pins.writeProtectN, {2{~pullLow}}, 5'h00};
                default: ioData = colReg;
            endcase
            idIdx++;
            colReg++;
        end
    end
    // released bus shows the inverse so a stale sample cannot pass
    always @(posedge pins.read_strobe_n) ioData = ~ioData;
endmodule : nisr_flash_model

/* File: tb/nisr_host_props.sv */
// checker: host-side command and strobe rules of the nand controller
// assumes binding to nisr_host; raw ready line seen unsynchronised
`timescale 1ns/1ps
module nisr_host_props
    import nisr_pkg::*;
(
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire nisr_pins_t  pins,
    input wire logic [7:0]  ioIn,
    input wire logic        ready_busy_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // =======================================
    // command beats
    sequence cmdBeat;
        pins.cmdLatch && !pins.writeStrobeN;
    endsequence
    sequence resumeCmd;
        cmdBeat ##0 pins.ioOut == 8'h00;
    endsequence
    known_cmd_a: assert property (cmdBeat |-> pins.ioOut inside {8'h90, 8'h70, 8'h00, 8'hff})
        else $error("command code outside set");
    busy_cmd_a: assert property (cmdBeat ##0 !ready_busy_n |-> pins.ioOut inside {8'h70, 8'hff})
        else $error("command other than status or reset while busy");
    id_addr_a: assert property (pins.addrLatch && !pins.writeStrobeN |-> pins.ioOut == 8'h00)
        else $error("address byte not zero");
    read_pulse_a: assert property ($fell(pins.read_strobe_n) |->
        !pins.read_strobe_n [*5] ##1 pins.read_strobe_n)
        else $error("read pulse width wrong");
    read_quiet_a: assert property (!pins.read_strobe_n |->
        pins.ioOeN && pins.writeStrobeN && !pins.chipEnableN)
        else $error("read strobe while driving");
    resume_noaddr_a: assert property (resumeCmd |=> !pins.addrLatch [*8])
        else $error("address cycle after resume");
endmodule : nisr_host_props
bind nisr_host nisr_host_props u_props (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pins, .ioIn, .ready_busy_n);

/* File: tb/nisr_host_test.sv */
// testbench: apb-driven id read, status read, reset and resume
// assumes nisr_host, the flash model and the bound checker
`timescale 1ns/1ps
`include "nisr_regs.svh"
module nisr_host_test
    import nisr_pkg::*;
;
    localparam logic [7:0] MAKER  = 8'h5a; // arbitrary value
    localparam logic [7:0] DEVICE = 8'h3c; // arbitrary value
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rdVal;
    logic        pready;
    logic        pslverr;
    logic        errVal;
    nisr_pins_t  pins;
    logic [7:0]  ioData;
    logic        pullLow;
    int          mismatches = 0;
    int          comparisons = 0;
    wire  [7:0]  ioWire = pins.ioOeN ? ioData : pins.ioOut;
    wire         rbWire = ~pullLow;
    nisr_host dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins), .ioIn(ioWire),
        .ready_busy_n(rbWire));
    nisr_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE), .BUSY_NS(1000)) far (.pins(pins),
        .pullLow(pullLow), .ioData(ioData));
    initial forever #4 clk = ~clk;
    // =======================================
    // tasks
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (pready !== 1'b1) begin
            mismatches++;
            report_and_stop();
        end
        rdVal = prdata;
        errVal = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic runOp(input nisr_op_t op, input logic wp, input logic [31:0] mask);
        int n;
        n = 0;
        if (op !== NISR_OP_ID || mask !== 32'h4) apb(1'b1, `NISR_CTRL_OFS, {28'h0, wp, op, 1'b1});
        do begin
            apb(1'b0, `NISR_STAT_OFS, 32'h0);
            n++;
        end while ((rdVal & mask) !== mask && n < 2000);
        if ((rdVal & mask) !== mask) begin
            mismatches++;
            report_and_stop();
        end
    endtask : runOp
    // =======================================
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        runOp(NISR_OP_ID, 1'b1, 32'h8);
        check(rdVal & 32'hf, 32'h8);
        runOp(NISR_OP_STATUS, 1'b1, 32'h2);
        apb(1'b0, `NISR_SREG_OFS, 32'h0);
        check(rdVal, 32'h80);
        runOp(NISR_OP_ID, 1'b1, 32'h4);
        $display("test power-on busy done");
        for (int wp = 0; wp < 2; wp++) begin
            runOp(NISR_OP_STATUS, wp[0], 32'h2);
            apb(1'b0, `NISR_SREG_OFS, 32'h0);
            check(rdVal, {24'h0, wp[0], 7'h60});
        end
        $display("test status done");
        runOp(NISR_OP_ID, 1'b1, 32'h2);
        apb(1'b0, `NISR_ID0_OFS, 32'h0);
        check(rdVal, {8'h15, 8'h80, DEVICE, MAKER});
        apb(1'b0, `NISR_ID1_OFS, 32'h0);
        check(rdVal, 32'h72);
        $display("test id done");
        runOp(NISR_OP_RESUME, 1'b1, 32'h2);
        runOp(NISR_OP_STATUS, 1'b1, 32'h2);
        apb(1'b0, `NISR_SREG_OFS, 32'h0);
        check(rdVal, 32'he0);
        runOp(NISR_OP_RESUME, 1'b1, 32'h2);
        runOp(NISR_OP_RESET, 1'b1, 32'h2);
        check(rdVal & 32'h7, 32'h6);
        apb(1'b0, `NISR_CTRL_OFS, 32'h0);
        check(rdVal, {28'h0, 1'b1, NISR_OP_RESET, 1'b0});
        runOp(NISR_OP_STATUS, 1'b1, 32'h2);
        apb(1'b0, `NISR_SREG_OFS, 32'h0);
        check(rdVal, 32'he0);
        apb(1'b0, 12'h020, 32'h0);
        check(rdVal, 32'h0);
        check({31'h0, errVal}, 32'h0);
        $display("test reset done");
        report_and_stop();
    end
endmodule : nisr_host_test
